// file: tppio_defs.svh
// constants for the three-port parallel i/o block
`ifndef TPPIO_DEFS_SVH
`define TPPIO_DEFS_SVH
// register offsets
`define TPPIO_ADDR_W 4
`define TPPIO_REG_PFIRST 4'h0
`define TPPIO_REG_PSECOND 4'h1
`define TPPIO_REG_PSPLIT 4'h2
`define TPPIO_REG_CTRL 4'h3
`define TPPIO_REG_STATUS 4'h4
`define TPPIO_REG_MASK 4'h5
`define TPPIO_REG_HS 4'h6
// control fields
`define TPPIO_CTRL_FMODE_LO 0
`define TPPIO_CTRL_FDIR 2
`define TPPIO_CTRL_SMODE 3
`define TPPIO_CTRL_SDIR 4
`define TPPIO_CTRL_SPLIT_UDIR 5
`define TPPIO_CTRL_SPLIT_LDIR 6
`define TPPIO_CTRL_RESET 8'h00
// port_split handshake bit positions
`define TPPIO_B_IRQ 0
`define TPPIO_B_FLAG 1
`define TPPIO_B_HS_IN 2
`define TPPIO_A_IRQ 3
`define TPPIO_A_STB 4
`define TPPIO_A_IBF 5
`define TPPIO_A_ACK 6
`define TPPIO_A_OBF 7
// status bits
`define TPPIO_ST_A_IN 0
`define TPPIO_ST_A_OUT 1
`define TPPIO_ST_B_EV 2
`define TPPIO_ST_W 3
`endif

// file: tppio_pkg.sv
// types for the three-port parallel i/o block
`default_nettype none
package tppio_pkg;
    typedef enum logic [1:0] {
        TPPIO_SIMPLE,
        TPPIO_STROBED,
        TPPIO_BIDIR,
        TPPIO_BAD
    } tppio_mode_t;
endpackage
`default_nettype wire

// file: tppio_top.sv
// three-port parallel i/o block with strobed handshakes
//
// Functional notes
// - first strobed in: bit4 strobe, bit5 full
// - first strobed out: bit6 ack, bit7 full_n
// - first handshake modes: irq on bit3
// - bits 0-2 serve second when strobed
// - bits 6,7 general, same direction
// - bits 4,5 general, same direction
// - bidir: bits 1,2 only if second simple
// - bidir: bit 0 never general i/o
// - second strobed in: bit1 full, bit2 strobe
// - second strobed out: bit1 full_n, bit2 ack
// - second strobed: irq on bit0
// - bit3 general only if first simple
// - split offers simple mode only
// - upper nibble general when first simple
// - lower nibble general only when both ports simple
// - both simple: split fully usable
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "tppio_defs.svh"

module tppio_top
    import tppio_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [`TPPIO_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // port_first pins
    input wire logic [7:0] first_in,
    output logic [7:0] first_out,
    output logic first_oe_n,
    // port_second pins
    input wire logic [7:0] second_in,
    output logic [7:0] second_out,
    output logic second_oe_n,
    // port_split pins
    input wire logic [7:0] split_in,
    output logic [7:0] split_out,
    output logic [7:0] split_oe_n,
    // interrupt
    output logic irq
);
    // ======================================
    // pin synchronisers
    logic [23:0] sync1;
    logic [23:0] sync2;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1 <= 24'hFFFFFF;
            sync2 <= 24'hFFFFFF;
        end else begin
            sync1 <= {split_in, second_in, first_in};
            sync2 <= sync1;
        end
    end
    logic [7:0] first_s;
    logic [7:0] second_s;
    logic [7:0] split_s;
    assign first_s = sync2[7:0];
    assign second_s = sync2[15:8];
    assign split_s = sync2[23:16];

    // ======================================
    // control register and decoded modes
    logic [7:0] ctrl;
    logic [7:0] mask;
    logic [7:0] hs_en;
    tppio_mode_t mode_a;
    tppio_mode_t mode_b;
    logic dir_a_out;
    logic dir_b_out;
    logic dir_up_out;
    logic dir_lo_out;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= `TPPIO_CTRL_RESET;
        end else if (reg_wr && reg_addr == `TPPIO_REG_CTRL) begin
            ctrl <= reg_wdata;
        end
    end
    always_comb begin
        unique case (ctrl[`TPPIO_CTRL_FMODE_LO +: 2])
            2'h0: mode_a = TPPIO_SIMPLE;
            2'h1: mode_a = TPPIO_STROBED;
            2'h2: mode_a = TPPIO_BIDIR;
            // undefined code falls back to simple mode
            default: mode_a = TPPIO_SIMPLE;
        endcase
    end
    // second port has no bidirectional code at all
    assign mode_b = ctrl[`TPPIO_CTRL_SMODE] ? TPPIO_STROBED : TPPIO_SIMPLE;
    assign dir_a_out = ctrl[`TPPIO_CTRL_FDIR];
    assign dir_b_out = ctrl[`TPPIO_CTRL_SDIR];
    // one direction bit per nibble keeps pairs in step
    assign dir_up_out = ctrl[`TPPIO_CTRL_SPLIT_UDIR];
    assign dir_lo_out = ctrl[`TPPIO_CTRL_SPLIT_LDIR];

    logic a_hs;
    logic b_hs;
    logic a_in_en;
    logic a_out_en;
    assign a_hs = mode_a != TPPIO_SIMPLE;
    assign b_hs = mode_b == TPPIO_STROBED;
    assign a_in_en = (mode_a == TPPIO_STROBED && !dir_a_out) || mode_a == TPPIO_BIDIR;
    assign a_out_en = (mode_a == TPPIO_STROBED && dir_a_out) || mode_a == TPPIO_BIDIR;

    // ======================================
    // strobe and acknowledge edge detect (active low)
    logic a_stb_n;
    logic a_ack_n;
    logic b_hs_n;
    logic a_stb_d;
    logic a_ack_d;
    logic b_hs_d;
    assign a_stb_n = split_s[`TPPIO_A_STB];
    assign a_ack_n = split_s[`TPPIO_A_ACK];
    assign b_hs_n = split_s[`TPPIO_B_HS_IN];
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_stb_d <= 1'b1;
            a_ack_d <= 1'b1;
            b_hs_d <= 1'b1;
        end else begin
            a_stb_d <= a_stb_n;
            a_ack_d <= a_ack_n;
            b_hs_d <= b_hs_n;
        end
    end
    logic a_stb_fall;
    logic a_stb_rise;
    logic a_ack_fall;
    logic a_ack_rise;
    logic b_fall;
    logic b_rise;
    assign a_stb_fall = a_stb_d && !a_stb_n;
    assign a_stb_rise = !a_stb_d && a_stb_n;
    assign a_ack_fall = a_ack_d && !a_ack_n;
    assign a_ack_rise = !a_ack_d && a_ack_n;
    assign b_fall = b_hs_d && !b_hs_n;
    assign b_rise = !b_hs_d && b_hs_n;

    logic wr_first;
    logic wr_second;
    logic rd_first;
    logic rd_second;
    assign wr_first = reg_wr && reg_addr == `TPPIO_REG_PFIRST;
    assign wr_second = reg_wr && reg_addr == `TPPIO_REG_PSECOND;
    assign rd_first = reg_rd && reg_addr == `TPPIO_REG_PFIRST;
    assign rd_second = reg_rd && reg_addr == `TPPIO_REG_PSECOND;

    // ======================================
    // port_first data latches and buffer flags
    logic [7:0] a_out_latch;
    logic [7:0] a_in_latch;
    logic a_ibf;
    logic a_obf;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_out_latch <= 8'h00;
        end else if (wr_first) begin
            a_out_latch <= reg_wdata;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_in_latch <= 8'h00;
        end else if (a_in_en && a_stb_fall) begin
            a_in_latch <= first_s;
        end
    end
    // strobe set beats a concurrent read clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_ibf <= 1'b0;
        end else if (a_in_en && a_stb_fall) begin
            a_ibf <= 1'b1;
        end else if (rd_first || !a_in_en) begin
            a_ibf <= 1'b0;
        end
    end
    // a new write beats a concurrent ack, which belonged to the old byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_obf <= 1'b0;
        end else if (a_out_en && wr_first) begin
            a_obf <= 1'b1;
        end else if (a_out_en && a_ack_fall) begin
            a_obf <= 1'b0;
        end else if (!a_out_en) begin
            a_obf <= 1'b0;
        end
    end

    // ======================================
    // port_second data latches and buffer flag
    logic [7:0] b_out_latch;
    logic [7:0] b_in_latch;
    logic b_flag;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            b_out_latch <= 8'h00;
        end else if (wr_second) begin
            b_out_latch <= reg_wdata;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            b_in_latch <= 8'h00;
        end else if (b_hs && !dir_b_out && b_fall) begin
            b_in_latch <= second_s;
        end
    end
    // input: high when full; output: held as "full" internally
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            b_flag <= 1'b0;
        end else if (!b_hs) begin
            b_flag <= 1'b0;
        end else if (!dir_b_out && b_fall) begin
            b_flag <= 1'b1;
        end else if ((!dir_b_out && rd_second) || (dir_b_out && wr_second)) begin
            b_flag <= dir_b_out;
        end else if (dir_b_out && b_fall) begin
            b_flag <= 1'b0;
        end
    end

    // ======================================
    // handshake interrupt enables and line requests
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hs_en <= 8'h00;
        end else if (reg_wr && reg_addr == `TPPIO_REG_HS) begin
            hs_en <= reg_wdata;
        end
    end
    logic group_a_irq;
    logic group_b_irq;
    // port_first request after strobe released with data held, or ack released with buffer empty; port_second on any strobe or ack release
    logic a_irq_q;
    logic b_irq_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_irq_q <= 1'b0;
        end else if ((a_in_en && a_stb_rise && a_ibf) || (a_out_en && a_ack_rise && !a_obf)) begin
            a_irq_q <= 1'b1;
        end else if (!a_hs || rd_first || wr_first) begin
            a_irq_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            b_irq_q <= 1'b0;
        end else if (b_hs && b_rise) begin
            b_irq_q <= 1'b1;
        end else if (!b_hs || rd_second || wr_second) begin
            b_irq_q <= 1'b0;
        end
    end
    assign group_a_irq = a_irq_q && hs_en[0];
    assign group_b_irq = b_irq_q && hs_en[1];

    // ======================================
    // port_split ownership and pin drive
    logic [7:0] split_latch;
    logic [7:0] gen_avail;
    logic [7:0] gen_dir_out;
    logic [7:0] hs_drive;
    logic [7:0] hs_value;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            split_latch <= 8'h00;
        end else if (reg_wr && reg_addr == `TPPIO_REG_PSPLIT) begin
            split_latch <= reg_wdata;
        end
    end
    always_comb begin
        gen_avail = 8'hFF;
        hs_drive = 8'h00;
        hs_value = 8'h00;
        if (b_hs) begin
            gen_avail[2:0] = 3'h0;
            hs_drive[`TPPIO_B_IRQ] = 1'b1;
            hs_drive[`TPPIO_B_FLAG] = 1'b1;
            hs_value[`TPPIO_B_IRQ] = group_b_irq;
            hs_value[`TPPIO_B_FLAG] = dir_b_out ? !b_flag : b_flag;
        end
        if (a_hs) begin
            gen_avail[`TPPIO_A_IRQ] = 1'b0;
            hs_drive[`TPPIO_A_IRQ] = 1'b1;
            hs_value[`TPPIO_A_IRQ] = group_a_irq;
        end
        if (a_in_en) begin
            gen_avail[`TPPIO_A_IBF] = 1'b0;
            gen_avail[`TPPIO_A_STB] = 1'b0;
            hs_drive[`TPPIO_A_IBF] = 1'b1;
            hs_value[`TPPIO_A_IBF] = a_ibf;
        end
        if (a_out_en) begin
            gen_avail[`TPPIO_A_ACK] = 1'b0;
            gen_avail[`TPPIO_A_OBF] = 1'b0;
            hs_drive[`TPPIO_A_OBF] = 1'b1;
            hs_value[`TPPIO_A_OBF] = !a_obf;
        end
        if (mode_a == TPPIO_BIDIR) begin
            gen_avail[0] = 1'b0;
            if (b_hs) begin
                gen_avail[2:1] = 2'h0;
            end
        end
    end
    assign gen_dir_out = {{4{dir_up_out}}, {4{dir_lo_out}}};

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            split_out <= 8'h00;
            split_oe_n <= 8'hFF;
        end else begin
            split_out <= (hs_value & hs_drive) | (split_latch & gen_avail & ~hs_drive);
            split_oe_n <= ~(hs_drive | (gen_avail & gen_dir_out));
        end
    end

    // ======================================
    // port_first and port_second pin drive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_out <= 8'h00;
            first_oe_n <= 1'b1;
            second_out <= 8'h00;
            second_oe_n <= 1'b1;
        end else begin
            first_out <= a_out_latch;
            // bidir drives only while peripheral holds ack low
            if (mode_a == TPPIO_BIDIR) begin
                first_oe_n <= a_ack_n;
            end else begin
                first_oe_n <= !dir_a_out;
            end
            second_out <= b_out_latch;
            second_oe_n <= !dir_b_out;
        end
    end

    // ======================================
    // event status and interrupt
    logic [`TPPIO_ST_W-1:0] status;
    logic [`TPPIO_ST_W-1:0] events;
    assign events = {b_hs && b_fall, a_out_en && a_ack_fall, a_in_en && a_stb_fall};
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status <= '0;
        end else if (reg_wr && reg_addr == `TPPIO_REG_STATUS) begin
            status <= (status & ~reg_wdata[`TPPIO_ST_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask <= 8'h00;
        end else if (reg_wr && reg_addr == `TPPIO_REG_MASK) begin
            mask <= reg_wdata;
        end
    end
    assign irq = |(status & mask[`TPPIO_ST_W-1:0]);

    // ======================================
    // read data, one cycle after the strobe
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `TPPIO_REG_PFIRST: next_rdata = a_in_en ? a_in_latch :
                (dir_a_out ? a_out_latch : first_s);
            `TPPIO_REG_PSECOND: next_rdata = (b_hs && !dir_b_out) ? b_in_latch :
                (dir_b_out ? b_out_latch : second_s);
            `TPPIO_REG_PSPLIT: next_rdata = (split_s & gen_avail & ~gen_dir_out) |
                (split_latch & gen_avail & gen_dir_out) | (hs_value & hs_drive);
            `TPPIO_REG_CTRL: next_rdata = ctrl;
            `TPPIO_REG_STATUS: next_rdata = {5'h00, status};
            `TPPIO_REG_MASK: next_rdata = mask;
            `TPPIO_REG_HS: next_rdata = {a_obf, a_ibf, b_flag, 3'h0, hs_en[1:0]};
            default: next_rdata = 8'h00;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// file: tppio_props.sv
// assertion checker for the three-port parallel i/o block
`timescale 1ns/10ps
`default_nettype none
`include "tppio_defs.svh"
module tppio_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [`TPPIO_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // split port and interrupt
    input wire logic [7:0] split_in,
    input wire logic [7:0] split_out,
    input wire logic [7:0] split_oe_n,
    input wire logic irq
);
    // ==========
    // shadow of the mode registers
    logic [7:0] ctl, hs, msk;
    logic [1:0] age;
    wire logic ok = &age;
    wire logic st_in = ok && (ctl[1:0] == 2'h2 || ctl[1:0] == 2'h1 && !ctl[2]);
    wire logic st_out = ok && ctl[1:0] == 2'h1 && ctl[2];
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl <= 8'h00;
            hs <= 8'h00;
            msk <= 8'h00;
            age <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == `TPPIO_REG_CTRL) ctl <= reg_wdata;
            if (reg_wr && reg_addr == `TPPIO_REG_HS) hs <= reg_wdata;
            if (reg_wr && reg_addr == `TPPIO_REG_MASK) msk <= reg_wdata;
            // pins follow a mode change a few edges late; judge only once settled
            if (reg_wr) age <= 2'h0;
            else if (!ok) age <= age + 2'h1;
        end
    end
    // ==========
    // properties
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_stb_fall;
        st_in && $fell(split_in[4]);
    endsequence
    sequence s_ibf_up;
        ##[2:8] split_out[5];
    endsequence
    a_ibf_rises: assert property (s_stb_fall |-> s_ibf_up)
        else $error("full flag missing after strobe");
    a_in_pins: assert property (st_in |-> !split_oe_n[5] && split_oe_n[4])
        else $error("strobed input pins misdriven");
    a_out_pins: assert property (st_out |-> !split_oe_n[7] && split_oe_n[6])
        else $error("strobed output pins misdriven");
    a_obf_falls: assert property (st_out && reg_wr
        && reg_addr == `TPPIO_REG_PFIRST |=> ##[0:3] !split_out[7])
        else $error("output full flag stayed high");
    a_irq_pin: assert property (ok && ctl[1:0] == 2'h1 && hs[0] |-> !split_oe_n[3])
        else $error("group a request pin not driven");
    a_b_pins: assert property (ok && ctl[3] |-> !split_oe_n[1] && split_oe_n[2])
        else $error("second handshake pins misdriven");
    a_b_irq_pin: assert property (ok && ctl[3] && hs[1] |-> !split_oe_n[0])
        else $error("group b request pin not driven");
    a_split_simple: assert property (ok && ctl[1] == ctl[0] && !ctl[3]
        |-> split_oe_n == {{4{!ctl[5]}}, {4{!ctl[6]}}})
        else $error("split directions wrong");
    a_irq_masked: assert property (ok && msk == 8'h00 |-> !irq)
        else $error("interrupt with all masked");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    a_reset_idle: assert property ($fell(rst) |-> &split_oe_n)
        else $error("split pins driven after reset");
endmodule
`default_nettype wire

// file: tppio_periph.sv
// peripheral model on the parallel port lines
`timescale 1ns/10ps
`default_nettype none
module tppio_periph (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bench commands
    input wire logic go,
    input wire logic sel_b,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic [7:0] data,
    input wire logic [7:0] gp,
    // port lines
    input wire logic [7:0] split_out,
    output logic [7:0] port_drv,
    output logic [7:0] split_drv
);
    logic [3:0] ts;
    logic [4:0] tk;
    logic on_b;
    // data stays well past the strobe so the input sync sees it settled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ts <= 4'h0;
            port_drv <= 8'h00;
        end else if (go) begin
            ts <= 4'h9;
            on_b <= sel_b;
            port_drv <= data;
        end else if (ts != 4'h0) begin
            ts <= ts - 4'h1;
            // released lines no longer show the last value
            if (ts == 4'h1) port_drv <= ~port_drv;
        end
    end
    // idle tail after each ack so one full buffer earns one ack
    always_ff @(posedge clk_sys) begin
        if (rst) tk <= 5'h00;
        else if (tk != 5'h00) tk <= tk - 5'h01;
        else if (ack_en && !split_out[7]) tk <= {1'b0, ack_wait} + 5'h0C;
    end
    always_comb begin
        split_drv = gp;
        split_drv[4] = !(ts > 4'h6 && !on_b);
        split_drv[2] = !(ts > 4'h6 && on_b);
        split_drv[6] = !(tk > 5'h03 && tk < 5'h07);
    end
endmodule
`default_nettype wire

// file: test_three_port_parallel_io_modes.sv
// self-checking bench for the three-port parallel i/o block
`timescale 1ns/10ps
`default_nettype none
`include "tppio_defs.svh"
`define CHK(n, e, s) \
    begin \
        checks_done++; \
        if ((s) !== (e)) begin \
            num_errors++; \
            $display("[ERR] %s exp %0h got %0h", n, e, s); \
        end \
    end
module test_three_port_parallel_io_modes;
    logic clk_sys, irq, first_oe_n, second_oe_n;
    logic rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, sel_b = 1'b0, ack_en = 1'b0;
    logic [3:0] reg_addr = 4'h0, ack_wait = 4'h0;
    logic [7:0] reg_wdata = 8'h00, pdata = 8'h00, gp = 8'h00;
    logic [7:0] reg_rdata, first_out, second_out, split_out, split_oe_n, port_drv, split_drv;
    logic [7:0] first_in, second_in, split_in, v, d, c;
    logic [31:0] seed = 32'h31BC;
    int num_errors = 0;
    int checks_done = 0;
    // each line carries whoever drives it
    assign first_in = first_oe_n ? port_drv : first_out;
    assign second_in = second_oe_n ? port_drv : second_out;
    assign split_in = split_oe_n & split_drv | ~split_oe_n & split_out;
    tppio_top uut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .first_in, .first_out, .first_oe_n, .second_in, .second_out, .second_oe_n,
        .split_in, .split_out, .split_oe_n, .irq);
    tppio_periph per (.clk_sys, .rst, .go, .sel_b, .ack_en, .ack_wait, .data(pdata), .gp,
        .split_out, .port_drv, .split_drv);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // ==========
    // helpers
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] oe_exp(input logic [7:0] m);
        return {{4{~m[5]}}, {4{~m[6]}}};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] x);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic strobe(input logic b);
        d = rnd();
        pdata <= d;
        sel_b <= b;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (int k = 0; k < 12 && split_out[b ? 1 : 5] !== 1'b1; k++) @(posedge clk_sys);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end
    // ==========
    // scenarios
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("split_oe_n", 8'hFF, split_oe_n)
        `CHK("first_oe_n", 1'b1, first_oe_n)
        rd(`TPPIO_REG_CTRL);
        `CHK("ctrl", `TPPIO_CTRL_RESET, v)
        $display("reset test done");
        // code 3 on the first port must behave as simple
        for (int i = 0; i < 6; i++) begin
            c = rnd() & 8'h74 | (i == 5 ? 8'h03 : 8'h00);
            wr(`TPPIO_REG_CTRL, c);
            d = rnd();
            // partner keeps its strobe and ack lines idle high
            gp <= rnd() | 8'h54;
            wr(`TPPIO_REG_PFIRST, d);
            wr(`TPPIO_REG_PSECOND, d);
            wr(`TPPIO_REG_PSPLIT, d);
            `CHK("split_oe_n", oe_exp(c), split_oe_n)
            `CHK("first_oe_n", ~c[2], first_oe_n)
            `CHK("second_oe_n", ~c[4], second_oe_n)
            `CHK("second_out", d, second_out)
            rd(`TPPIO_REG_PFIRST);
            `CHK("first", c[2] ? d : port_drv, c[2] ? first_out : v)
            rd(`TPPIO_REG_PSPLIT);
            `CHK("split lo", c[6] ? d[3:0] : gp[3:0], c[6] ? split_out[3:0] : v[3:0])
            `CHK("split", {c[5] ? d[7:4] : gp[7:4], c[6] ? d[3:0] : gp[3:0]}, v)
        end
        wr(4'hF, 8'hA5);
        rd(4'hF);
        `CHK("unmapped", 8'h00, v)
        $display("simple mode test done");
        // strobed input, then bidirectional with the interrupt masked
        for (int m = 1; m < 3; m++) begin
            wr(`TPPIO_REG_CTRL, m[7:0]);
            wr(`TPPIO_REG_HS, 8'h03);
            wr(`TPPIO_REG_MASK, m == 1 ? 8'h01 : 8'h00);
            repeat (3) @(posedge clk_sys);
            strobe(1'b0);
            `CHK("ibf", 1'b1, split_out[5])
            `CHK("irq", m == 1, irq)
            // request follows the synchronised strobe release
            repeat (3) @(posedge clk_sys);
            if (m == 1) `CHK("a irq pin", 1'b1, split_out[3])
            rd(`TPPIO_REG_PFIRST);
            `CHK("first data", d, v)
            @(posedge clk_sys);
            `CHK("ibf", 1'b0, split_out[5])
            wr(`TPPIO_REG_STATUS, 8'hFF);
            `CHK("irq clear", 1'b0, irq)
        end
        $display("strobed input test done");
        wr(`TPPIO_REG_CTRL, 8'h05);
        wr(`TPPIO_REG_MASK, 8'h02);
        ack_en <= 1'b1;
        // two acks, each after a random wait
        for (int i = 0; i < 2; i++) begin
            repeat (3) @(posedge clk_sys);
            d = rnd();
            ack_wait <= d[3:0];
            wr(`TPPIO_REG_PFIRST, d);
            @(posedge clk_sys);
            `CHK("obf_n", 1'b0, split_out[7])
            `CHK("first_out", d, first_out)
            for (int k = 0; k < 40 && split_out[7] !== 1'b1; k++) @(posedge clk_sys);
            `CHK("obf_n", 1'b1, split_out[7])
            `CHK("irq", 1'b1, irq)
            wr(`TPPIO_REG_STATUS, 8'hFF);
        end
        ack_en <= 1'b0;
        $display("strobed output test done");
        wr(`TPPIO_REG_CTRL, 8'h08);
        wr(`TPPIO_REG_HS, 8'h02);
        wr(`TPPIO_REG_MASK, 8'h04);
        repeat (3) @(posedge clk_sys);
        strobe(1'b1);
        `CHK("ibf b", 1'b1, split_out[1])
        `CHK("irq", 1'b1, irq)
        repeat (3) @(posedge clk_sys);
        `CHK("b irq pin", 1'b1, split_out[0])
        rd(`TPPIO_REG_PSECOND);
        `CHK("second data", d, v)
        wr(`TPPIO_REG_CTRL, 8'h18);
        wr(`TPPIO_REG_PSECOND, d);
        @(posedge clk_sys);
        `CHK("obf b", 1'b0, split_out[1])
        `CHK("second_out", d, second_out)
        `CHK("second_oe_n", 1'b0, second_oe_n)
        strobe(1'b1);
        `CHK("obf b", 1'b1, split_out[1])
        $display("second port test done");
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK("split_oe_n", 8'hFF, split_oe_n)
        $display("second reset test done");
        final_report();
    end
endmodule
bind tppio_top tppio_props chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .split_in, .split_out, .split_oe_n, .irq);
`default_nettype wire
